// ==== design/table_access_params.svh ====
// constants for the static / reserved multicast table access block
// assumes a 32-bit word register port addressed by byte offsets
`ifndef TABLE_ACCESS_PARAMS_SVH
`define TABLE_ACCESS_PARAMS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define TA_ADDR_W 16
`define TA_CTRL_OFS 16'h041c
`define TA_ENTRY1_OFS 16'h0420
`define TA_ENTRY2_OFS 16'h0424
`define TA_ENTRY3_OFS 16'h0428
`define TA_ENTRY4_OFS 16'h042c

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define TA_IDX_HI 21
`define TA_IDX_LO 16
`define TA_ST_IDX_HI 19
`define TA_START_BIT 7
`define TA_RSV_HI 6
`define TA_RSV_LO 2
`define TA_SEL_BIT 1
`define TA_ACT_BIT 0
`define TA_SEL_MCAST 1'b1
`define TA_ACT_READ 1'b1

// ------------------------------------------------------------------
// reset values and table shapes
// ------------------------------------------------------------------
`define TA_CTRL_RESET 32'h0000_0000
`define TA_ENTRY_RESET 32'h0000_0000
`define TA_ENTRY_WORDS 4
`define TA_MC_WORD 1
`define TA_ST_AW 4
`define TA_MC_AW 6
`define TA_ST_ROWS 16
`define TA_MC_ROWS 64
`define TA_WORD_W 32
`define TA_ST_W 128

`endif

// ==== design/table_access_pkg.sv ====
// types shared by the table access block
// assumes table_access_params.svh supplies the numbers
package table_access_pkg;

    // ------------------------------------------------------------------
    // access sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_ISSUE = 3'b010,
        S_FINISH = 3'b100
    } access_state_t;

endpackage : table_access_pkg

// ==== design/table_store.sv ====
// storage arrays for the static and reserved multicast tables
// assumes one access at a time, read data valid one edge after enable
`timescale 1ns/1ps
`include "table_access_params.svh"

module table_store (
    input wire logic sys_clk,
    input wire logic st_en,
    input wire logic st_we,
    input wire logic [`TA_ST_AW-1:0] st_addr,
    input wire logic [`TA_ST_W-1:0] st_wdata,
    output logic [`TA_ST_W-1:0] st_rdata,
    input wire logic mc_en,
    input wire logic mc_we,
    input wire logic [`TA_MC_AW-1:0] mc_addr,
    input wire logic [`TA_WORD_W-1:0] mc_wdata,
    output logic [`TA_WORD_W-1:0] mc_rdata
);

    logic [`TA_ST_W-1:0] st_mem [0:`TA_ST_ROWS-1];
    logic [`TA_WORD_W-1:0] mc_mem [0:`TA_MC_ROWS-1];

    // ------------------------------------------------------------------
    // static table
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (st_en) begin
            if (st_we) begin
                st_mem[st_addr] <= st_wdata;
            end
            st_rdata <= st_mem[st_addr];
        end
    end

    // ------------------------------------------------------------------
    // reserved multicast table
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (mc_en) begin
            if (mc_we) begin
                mc_mem[mc_addr] <= mc_wdata;
            end
            mc_rdata <= mc_mem[mc_addr];
        end
    end

endmodule : table_store

// ==== design/static_mcast_table_access.sv ====
// control register, entry words and access sequencer for the two tables
// assumes a synchronous 32-bit register port; one access runs at a time
`timescale 1ns/1ps
`include "table_access_params.svh"

module static_mcast_table_access (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [`TA_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`TA_WORD_W-1:0] reg_wdata,
    output logic [`TA_WORD_W-1:0] reg_rdata,
    output logic reg_rvalid
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    table_access_pkg::access_state_t state;
    table_access_pkg::access_state_t next_state;
    logic [`TA_IDX_HI-`TA_IDX_LO:0] ctrl_index;
    logic [`TA_IDX_HI-`TA_IDX_LO:0] next_ctrl_index;
    logic go_done_flag;
    logic next_go_done_flag;
    logic [`TA_RSV_HI-`TA_RSV_LO:0] ctrl_rsv;
    logic [`TA_RSV_HI-`TA_RSV_LO:0] next_ctrl_rsv;
    logic ctrl_sel;
    logic next_ctrl_sel;
    logic ctrl_act;
    logic next_ctrl_act;
    logic [`TA_WORD_W-1:0] entry [0:`TA_ENTRY_WORDS-1];
    logic [`TA_WORD_W-1:0] next_entry [0:`TA_ENTRY_WORDS-1];
    logic [`TA_WORD_W-1:0] next_reg_rdata;
    logic next_reg_rvalid;

    logic accept;
    logic mem_go;
    logic st_en;
    logic st_we;
    logic mc_en;
    logic mc_we;
    logic [`TA_ST_AW-1:0] st_addr;
    logic [`TA_MC_AW-1:0] mc_addr;
    logic [`TA_ST_W-1:0] st_wdata;
    logic [`TA_ST_W-1:0] st_rdata;
    logic [`TA_WORD_W-1:0] mc_rdata;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // entry slot for an address, or -1 when it is not an entry word
    function automatic int entry_slot(input logic [`TA_ADDR_W-1:0] addr);
        int slot;
        slot = -1;
        unique case (addr)
            `TA_ENTRY1_OFS: slot = 0;
            `TA_ENTRY2_OFS: slot = 1;
            `TA_ENTRY3_OFS: slot = 2;
            `TA_ENTRY4_OFS: slot = 3;
            default: slot = -1;
        endcase
        return slot;
    endfunction : entry_slot

    function automatic logic [`TA_WORD_W-1:0] ctrl_word(
        input logic [`TA_IDX_HI-`TA_IDX_LO:0] idx,
        input logic start,
        input logic [`TA_RSV_HI-`TA_RSV_LO:0] rsv,
        input logic sel,
        input logic act
    );
        logic [`TA_WORD_W-1:0] w;
        w = `TA_CTRL_RESET;
        w[`TA_IDX_HI:`TA_IDX_LO] = idx;
        w[`TA_START_BIT] = start;
        w[`TA_RSV_HI:`TA_RSV_LO] = rsv;
        w[`TA_SEL_BIT] = sel;
        w[`TA_ACT_BIT] = act;
        return w;
    endfunction : ctrl_word

    // one word of a static row, word 0 in the lowest bits
    function automatic logic [`TA_WORD_W-1:0] row_word(input logic [`TA_ST_W-1:0] row,
        input int k);
        return row[k*`TA_WORD_W +: `TA_WORD_W];
    endfunction : row_word

    // registers take writes only while no access is pending or running
    assign accept = (state == table_access_pkg::S_IDLE) && !go_done_flag;
    assign mem_go = (state == table_access_pkg::S_ISSUE);

    // ------------------------------------------------------------------
    // table ports
    // ------------------------------------------------------------------
    // table selector steering
    assign mc_en = mem_go && (ctrl_sel == `TA_SEL_MCAST);
    assign st_en = mem_go && (ctrl_sel != `TA_SEL_MCAST);
    assign mc_we = mc_en && (ctrl_act != `TA_ACT_READ);
    assign st_we = st_en && (ctrl_act != `TA_ACT_READ);
    assign mc_addr = ctrl_index;
    assign st_addr = ctrl_index[`TA_ST_IDX_HI-`TA_IDX_LO:0];
    // static row is the four words side by side
    assign st_wdata = {entry[3], entry[2], entry[1], entry[0]};

    table_store u_store (
        .sys_clk(sys_clk),
        .st_en(st_en),
        .st_we(st_we),
        .st_addr(st_addr),
        .st_wdata(st_wdata),
        .st_rdata(st_rdata),
        .mc_en(mc_en),
        .mc_we(mc_we),
        .mc_addr(mc_addr),
        // multicast data from entry word 2
        .mc_wdata(entry[`TA_MC_WORD]),
        .mc_rdata(mc_rdata)
    );

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    always_comb begin
        int wslot;
        int rslot;
        wslot = entry_slot(reg_addr);
        rslot = entry_slot(reg_addr);
        next_state = state;
        next_ctrl_index = ctrl_index;
        next_go_done_flag = go_done_flag;
        next_ctrl_rsv = ctrl_rsv;
        next_ctrl_sel = ctrl_sel;
        next_ctrl_act = ctrl_act;
        for (int i = 0; i < `TA_ENTRY_WORDS; i++) begin
            next_entry[i] = entry[i];
        end

        // software writes
        if (reg_wr && accept) begin
            if (reg_addr == `TA_CTRL_OFS) begin
                next_ctrl_index = reg_wdata[`TA_IDX_HI:`TA_IDX_LO];
                next_go_done_flag = reg_wdata[`TA_START_BIT];
                next_ctrl_rsv = reg_wdata[`TA_RSV_HI:`TA_RSV_LO];
                next_ctrl_sel = reg_wdata[`TA_SEL_BIT];
                next_ctrl_act = reg_wdata[`TA_ACT_BIT];
            end else if (wslot >= 0) begin
                next_entry[wslot[1:0]] = reg_wdata;
            end
        end

        // sequencer
        unique case (state)
            table_access_pkg::S_IDLE: begin
                if (go_done_flag) begin
                    next_state = table_access_pkg::S_ISSUE;
                end
            end
            table_access_pkg::S_ISSUE: begin
                next_state = table_access_pkg::S_FINISH;
            end
            table_access_pkg::S_FINISH: begin
                if (ctrl_act == `TA_ACT_READ) begin
                    if (ctrl_sel == `TA_SEL_MCAST) begin
                        // multicast result lands in word 2 only
                        next_entry[`TA_MC_WORD] = mc_rdata;
                    end else begin
                        // static result fills all four words
                        for (int k = 0; k < `TA_ENTRY_WORDS; k++) begin
                            next_entry[k] = row_word(st_rdata, k);
                        end
                    end
                end
                next_go_done_flag = 1'b0;
                next_state = table_access_pkg::S_IDLE;
            end
            default: begin
                next_state = table_access_pkg::S_IDLE;
            end
        endcase

        // software reads
        next_reg_rvalid = reg_rd;
        next_reg_rdata = `TA_CTRL_RESET;
        if (reg_rd) begin
            if (reg_addr == `TA_CTRL_OFS) begin
                next_reg_rdata = ctrl_word(ctrl_index, go_done_flag, ctrl_rsv,
                    ctrl_sel, ctrl_act);
            end else if (rslot >= 0) begin
                next_reg_rdata = entry[rslot[1:0]];
            end
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= table_access_pkg::S_IDLE;
            ctrl_index <= '0;
            go_done_flag <= 1'b0;
            ctrl_rsv <= '0;
            ctrl_sel <= 1'b0;
            ctrl_act <= 1'b0;
            for (int i = 0; i < `TA_ENTRY_WORDS; i++) begin
                entry[i] <= `TA_ENTRY_RESET;
            end
            reg_rdata <= `TA_CTRL_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            ctrl_index <= next_ctrl_index;
            go_done_flag <= next_go_done_flag;
            ctrl_rsv <= next_ctrl_rsv;
            ctrl_sel <= next_ctrl_sel;
            ctrl_act <= next_ctrl_act;
            for (int i = 0; i < `TA_ENTRY_WORDS; i++) begin
                entry[i] <= next_entry[i];
            end
            reg_rdata <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic fin_read;
    assign fin_read = (state == table_access_pkg::S_FINISH) && (ctrl_act == `TA_ACT_READ);

    sequence s_pending;
        go_done_flag [*3];
    endsequence

    sequence s_cleared;
        !go_done_flag && (state == table_access_pkg::S_IDLE);
    endsequence

    sequence s_issue;
        state == table_access_pkg::S_ISSUE;
    endsequence

    sequence s_finish;
        state == table_access_pkg::S_FINISH;
    endsequence

    a_mcast_row_index: assert property (
        mc_we |=> u_store.mc_mem[$past(ctrl_index)] == $past(entry[`TA_MC_WORD]))
        else $error("multicast row does not follow index");

    a_static_row_index: assert property (
        st_we |=> u_store.st_mem[$past(ctrl_index[`TA_ST_IDX_HI-`TA_IDX_LO:0])]
            == $past(st_wdata))
        else $error("static row does not follow low index bits");

    a_access_steps: assert property (
        $rose(go_done_flag) |=> s_issue ##1 s_finish)
        else $error("access did not step through issue and finish");

    a_busy_lockout: assert property (
        (go_done_flag && reg_wr && (state != table_access_pkg::S_FINISH))
            |=> $stable(entry[0]) && $stable(ctrl_index) && $stable(ctrl_act))
        else $error("register changed while an access was running");

    a_read_answer: assert property (
        reg_rd |=> reg_rvalid)
        else $error("read strobe got no answer");

    a_start_self_clear: assert property (
        $rose(go_done_flag) |-> s_pending ##1 s_cleared)
        else $error("start bit not cleared three cycles after set");

    a_table_select: assert property (
        mem_go |-> (mc_en == ctrl_sel) && (st_en == !ctrl_sel))
        else $error("access sent to the wrong table");

    a_action_write: assert property (
        mem_go |-> ((mc_we || st_we) == !ctrl_act))
        else $error("write enable disagrees with action bit");

    a_mcast_word_only: assert property (
        (fin_read && ctrl_sel) |=> $stable(entry[0]) && $stable(entry[2])
            && $stable(entry[3]) && entry[1] == $past(mc_rdata))
        else $error("multicast read touched the wrong entry word");

    a_static_read_back: assert property (
        (fin_read && !ctrl_sel) |=> entry[0] == $past(st_rdata[31:0])
            && entry[3] == $past(st_rdata[127:96]))
        else $error("static read result not in entry words");

    a_entry_layout: assert property (
        (st_we |-> st_wdata[63:32] == entry[1]) and (mc_we |-> !st_we))
        else $error("entry words not laid out for the selected table");

endmodule : static_mcast_table_access

// ==== tb/static_mcast_table_access_tb.sv ====
// self-checking bench for the static / reserved multicast table access block
// assumes table_access_params.svh on the include path and the design files compiled first
`timescale 1ns/1ps
`include "table_access_params.svh"

module static_mcast_table_access_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`TA_ADDR_W-1:0] reg_addr = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [`TA_WORD_W-1:0] reg_wdata = '0;
    logic [`TA_WORD_W-1:0] reg_rdata;
    logic reg_rvalid;
    int failures = 0;
    int samples_checked = 0;
    // ------------------------------------------------------------------
    // reference model state
    // ------------------------------------------------------------------
    logic [31:0] ent [4];
    logic [127:0] st_mem [16];
    logic [31:0] mc_mem [64];
    logic [5:0] ix [6];
    logic [5:0] m_idx = 6'h00;
    logic [4:0] m_rsv = 5'h00;
    logic m_sel = 1'b0;
    logic m_act = 1'b0;

    always #12.5 sys_clk = ~sys_clk;

    static_mcast_table_access dut (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        chk({31'h0, reg_rvalid}, 32'h1);
        d = reg_rdata;
    endtask : rd

    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask : rdchk

    function automatic logic [31:0] ctrl_exp(input logic s);
        return {10'h000, m_idx, 8'h00, s, m_rsv, m_sel, m_act};
    endfunction : ctrl_exp

    function automatic logic [31:0] mk(input logic [5:0] i, input logic s, input logic a);
        return {10'h000, i, 8'h00, 1'b0, 5'($urandom), s, a} | ($urandom & 32'hffc0_ff00);
    endfunction : mk

    task automatic set_ctrl(input logic [31:0] c);
        m_idx = c[21:16];
        m_rsv = c[6:2];
        m_sel = c[1];
        m_act = c[0];
    endtask : set_ctrl

    // load all four entry words with fresh random values
    task automatic ld;
        for (int i = 0; i < 4; i++) begin
            ent[i] = $urandom;
            wr(16'(`TA_ENTRY1_OFS + 4 * i), ent[i]);
        end
    endtask : ld

    task automatic chk_ents;
        for (int i = 0; i < 4; i++) begin
            rdchk(16'(`TA_ENTRY1_OFS + 4 * i), ent[i]);
        end
    endtask : chk_ents

    // start one access, then poll until the start bit drops
    task automatic go(input logic [31:0] c, input bit busy_wr);
        logic [31:0] v;
        int n;
        set_ctrl(c);
        wr(`TA_CTRL_OFS, c | 32'h0000_0080);
        if (busy_wr) begin
            wr(`TA_ENTRY1_OFS, $urandom);
        end else begin
            rd(`TA_CTRL_OFS, v);
            chk(v, ctrl_exp(1'b1));
        end
        n = 0;
        v = 32'h0000_0080;
        while (v[7] !== 1'b0 && n < 8) begin
            rd(`TA_CTRL_OFS, v);
            n++;
        end
        chk(v, ctrl_exp(1'b0));
        if (m_sel) begin
            if (m_act) ent[1] = mc_mem[m_idx];
            else mc_mem[m_idx] = ent[1];
        end else begin
            if (m_act) {ent[3], ent[2], ent[1], ent[0]} = st_mem[m_idx[3:0]];
            else st_mem[m_idx[3:0]] = {ent[3], ent[2], ent[1], ent[0]};
        end
        if (busy_wr) begin
            rdchk(`TA_ENTRY1_OFS, ent[0]);
        end
    endtask : go

    task automatic chk_reset_regs;
        for (int i = 0; i < 5; i++) begin
            rdchk(16'(`TA_CTRL_OFS + 4 * i), 32'h0000_0000);
        end
    endtask : chk_reset_regs

    initial begin
        #(25 * 20000);
        failures++;
        test_done();
    end

    initial begin
        logic [31:0] v;
        void'($urandom(32'h4df2050a));
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk_reset_regs();
        wr(16'h0430, $urandom);
        rdchk(16'h0430, 32'h0000_0000);
        $display("test reset_and_unmapped done");
        repeat (4) begin
            v = $urandom & 32'hffff_ff7f;
            wr(`TA_CTRL_OFS, v);
            set_ctrl(v);
            rdchk(`TA_CTRL_OFS, ctrl_exp(1'b0));
        end
        ld();
        chk_ents();
        $display("test register_storage done");
        for (int r = 0; r < 6; r++) begin
            ix[r] = (r == 0) ? 6'h00 : (r == 1) ? 6'h3f : 6'($urandom);
            ld();
            go(mk(ix[r], 1'b0, 1'b0), r == 2);
        end
        for (int r = 0; r < 6; r++) begin
            ld();
            go(mk(ix[r] ^ 6'h30, 1'b0, 1'b1), 1'b0);
            chk_ents();
        end
        $display("test static_table done");
        for (int r = 0; r < 6; r++) begin
            ix[r] = (r == 0) ? 6'h00 : (r == 1) ? 6'h3f : 6'($urandom);
            ld();
            go(mk(ix[r], 1'b1, 1'b0), r == 3);
        end
        for (int r = 5; r >= 0; r--) begin
            ld();
            go(mk(ix[r], 1'b1, 1'b1), 1'b0);
            chk_ents();
        end
        $display("test multicast_table done");
        @(posedge sys_clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk_reset_regs();
        $display("test second_reset done");
        test_done();
    end
endmodule : static_mcast_table_access_tb
